/* File: kwd_watchdog.sv */
/*
  kwd_watchdog: keyed watchdog timer with software reset.
  Assumes CPU idle and power-down come as same-clock levels, the external
  reset level as a pin strap (synchronised), and that the reset pulse is
  fed back to the system reset only after this block has flagged its cause.
*/
// Design decision made here: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module kwd_watchdog
  import kwd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic cpu_idle,
  input wire logic power_down,
  input wire logic [KWD_PRE_W-1:0] timer_prescale,
  input wire logic reset_active_level,
  output logic cpu_reset,
  output logic rst_pin_out,
  output logic rst_pin_oe
);
  // ****************************************************************
  // state
  // ****************************************************************
  // the soft and time-out flags in this register are cleared by a software write or by the bus reset input,
  // which the system does not pulse on a watchdog reset
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;
  kwd_key_e key_ff;
  kwd_key_e nxt_key;
  logic running_ff;
  logic nxt_running;
  logic [1:0] pulse_ff;
  logic [1:0] nxt_pulse;
  logic cpu_reset_ff;
  logic pin_out_ff;
  logic pin_oe_ff;
  logic [2:0] lvl_sync_ff;
  logic lvl_ff;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  logic key_wr;
  logic ctrl_wr;
  logic other_wr;
  logic ctrl_rd;
  logic feed_done;
  logic soft_done;
  logic bad_seq;
  logic chain_step;
  logic chain_ovf;
  logic fire;

  assign key_wr = reg_wr && (reg_addr == KWD_KEY_ADDR);
  assign ctrl_wr = reg_wr && (reg_addr == KWD_CTRL_ADDR);
  // any write elsewhere in register space breaks a half-done sequence
  assign other_wr = reg_wr && !key_wr;
  assign ctrl_rd = reg_rd && (reg_addr == KWD_CTRL_ADDR);

  // ****************************************************************
  // key sequence decoder
  // ****************************************************************
  // reads never move the sequencer, so they pass between the keys
  always_comb begin
    nxt_key = key_ff;
    feed_done = 1'b0;
    soft_done = 1'b0;
    bad_seq = 1'b0;
    unique case (key_ff)
      KWD_K_IDLE: begin
        if (key_wr) begin
          if (reg_wdata == KWD_FEED_KEY1) begin
            nxt_key = KWD_K_FEED;
          end else if (reg_wdata == KWD_SOFT_KEY1) begin
            nxt_key = KWD_K_SOFT;
          end else begin
            bad_seq = 1'b1;
          end
        end
      end
      KWD_K_FEED: begin
        if (key_wr) begin
          nxt_key = KWD_K_IDLE;
          feed_done = (reg_wdata == KWD_FEED_KEY2);
          bad_seq = (reg_wdata != KWD_FEED_KEY2);
        end else if (other_wr) begin
          nxt_key = KWD_K_IDLE;
          bad_seq = 1'b1;
        end
      end
      KWD_K_SOFT: begin
        if (key_wr) begin
          nxt_key = KWD_K_IDLE;
          soft_done = (reg_wdata == KWD_SOFT_KEY2);
          bad_seq = (reg_wdata != KWD_SOFT_KEY2);
        end else if (other_wr) begin
          nxt_key = KWD_K_IDLE;
          bad_seq = 1'b1;
        end
      end
      default: begin
        nxt_key = KWD_K_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // counting
  // ****************************************************************
  // no count in power-down; idle stops it only when asked
  assign chain_step = running_ff && !power_down &&
                      !(cpu_idle && ctrl_ff[KWD_IDLE_STOP_BIT]);

  kwd_chain u_chain (
    .clk(clk),
    .arst_n(arst_n),
    .step(chain_step),
    .clear(feed_done || !running_ff),
    .sel(ctrl_ff[KWD_PS_HI:KWD_PS_LO]),
    .prescale(timer_prescale),
    .overflow(chain_ovf)
  );

  // a reset is launched by time-out, soft key pair or bad sequence
  assign fire = chain_ovf || soft_done || bad_seq;

  // running: set by a completed 1E/E1, dropped by any reset we cause
  assign nxt_running = fire ? 1'b0 : (feed_done ? 1'b1 : running_ff);

  // ****************************************************************
  // control register
  // ****************************************************************
  // software may write select, idle-stop and inhibit, and clear flags;
  // hardware set beats a same-cycle software clear
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (ctrl_wr) begin
      nxt_ctrl[KWD_PS_HI:KWD_INHIBIT_BIT] = reg_wdata[KWD_PS_HI:KWD_INHIBIT_BIT];
      nxt_ctrl[KWD_SOFT_FLAG_BIT] = reg_wdata[KWD_SOFT_FLAG_BIT];
      nxt_ctrl[KWD_TIMEOUT_FLAG_BIT] = reg_wdata[KWD_TIMEOUT_FLAG_BIT];
    end
    if (soft_done || bad_seq) begin
      nxt_ctrl[KWD_SOFT_FLAG_BIT] = 1'b1;
    end
    if (chain_ovf || bad_seq) begin
      nxt_ctrl[KWD_TIMEOUT_FLAG_BIT] = 1'b1;
    end
    nxt_ctrl[KWD_RUNNING_BIT] = nxt_running; // writes ignored
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  // the key register reads as zero: no stored key is ever visible
  assign nxt_rdata = ctrl_rd ? ctrl_ff : 8'h00;

  // ****************************************************************
  // reset pulse
  // ****************************************************************
  assign nxt_pulse = fire ? 2'(KWD_RST_PULSE_CYC) :
                     (pulse_ff != 2'h0 ? pulse_ff - 2'h1 : 2'h0);

  // strap for the pin level, caught through three stages
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_sync_ff <= 3'h0;
      lvl_ff <= 1'b0;
    end else begin
      lvl_sync_ff <= {lvl_sync_ff[1:0], reset_active_level};
      if (lvl_sync_ff[1] == lvl_sync_ff[2]) begin
        lvl_ff <= lvl_sync_ff[2];
      end
    end
  end

  // main state registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= KWD_CTRL_RESET;
      key_ff <= KWD_K_IDLE;
      running_ff <= 1'b0;
      rdata_ff <= 8'h00;
      pulse_ff <= 2'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      key_ff <= nxt_key;
      running_ff <= nxt_running;
      rdata_ff <= nxt_rdata;
      pulse_ff <= nxt_pulse;
    end
  end

  // registered outputs; pin drives the strap level during the pulse unless inhibited
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_reset_ff <= 1'b0;
      pin_out_ff <= 1'b0;
      pin_oe_ff <= 1'b0;
    end else begin
      cpu_reset_ff <= (pulse_ff != 2'h0);
      pin_out_ff <= lvl_ff;
      pin_oe_ff <= (pulse_ff != 2'h0) && !ctrl_ff[KWD_INHIBIT_BIT];
    end
  end

  assign reg_rdata = rdata_ff;
  assign cpu_reset = cpu_reset_ff;
  assign rst_pin_out = pin_out_ff;
  assign rst_pin_oe = pin_oe_ff;
endmodule : kwd_watchdog
`default_nettype wire

/* File: kwd_pkg.sv */
/*
  kwd_pkg: shared constants for the keyed watchdog with soft reset.
  Assumes an 8-bit special function register space reached by a plain strobe port.
*/
package kwd_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] KWD_KEY_ADDR = 8'hA6;
  localparam logic [7:0] KWD_CTRL_ADDR = 8'hA7;
  localparam logic [7:0] KWD_CTRL_RESET = 8'h00;
  // control field positions
  localparam int KWD_PS_HI = 7;
  localparam int KWD_PS_LO = 5;
  localparam int KWD_IDLE_STOP_BIT = 4;
  localparam int KWD_INHIBIT_BIT = 3;
  localparam int KWD_SOFT_FLAG_BIT = 2;
  localparam int KWD_TIMEOUT_FLAG_BIT = 1;
  localparam int KWD_RUNNING_BIT = 0;
  // key bytes
  localparam logic [7:0] KWD_FEED_KEY1 = 8'h1E;
  localparam logic [7:0] KWD_FEED_KEY2 = 8'hE1;
  localparam logic [7:0] KWD_SOFT_KEY1 = 8'h5A;
  localparam logic [7:0] KWD_SOFT_KEY2 = 8'hA5;
  // ****************************************************************
  // counting chain
  // ****************************************************************
  localparam int KWD_PRE_W = 7;
  localparam int KWD_TMR_W = 14;
  localparam int KWD_SEL_W = 3;
  localparam int KWD_RST_PULSE_CYC = 2; // length of the internal reset pulse
  // key sequence states
  typedef enum logic [1:0] {
    KWD_K_IDLE = 2'b00,
    KWD_K_FEED = 2'b01,
    KWD_K_SOFT = 2'b10
  } kwd_key_e;
endpackage : kwd_pkg

/* File: kwd_chain.sv */
/*
  kwd_chain: prescaler plus 14-bit timer of the watchdog.
  Assumes step, clear and period select come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module kwd_chain
  import kwd_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic step,
  input wire logic clear,
  input wire logic [KWD_SEL_W-1:0] sel,
  input wire logic [KWD_PRE_W-1:0] prescale,
  output logic overflow
);
  // ****************************************************************
  // chain
  // ****************************************************************
  logic [KWD_PRE_W-1:0] pre_ff;
  logic [KWD_PRE_W-1:0] sub_ff;
  logic [KWD_TMR_W-1:0] tmr_ff;
  logic pre_wrap;
  logic sub_wrap;
  logic [KWD_PRE_W-1:0] sub_limit;
  logic tmr_wrap;

  // the timer prescale stretches each tick by (prescale+1)
  assign pre_wrap = step && (pre_ff == prescale);
  // period select: 2^sel divider in front of the 14-bit timer
  assign sub_limit = KWD_PRE_W'((8'h01 << sel) - 8'h01);
  assign sub_wrap = pre_wrap && (sub_ff == sub_limit);
  assign tmr_wrap = sub_wrap && (&tmr_ff);
  assign overflow = tmr_wrap; // 14-bit overflow marks time-out

  // 7-bit prescaler, then 14-bit timer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_ff <= '0;
      sub_ff <= '0;
      tmr_ff <= '0;
    end else if (clear) begin // feed restarts a whole period
      pre_ff <= '0;
      sub_ff <= '0;
      tmr_ff <= '0;
    end else if (step) begin
      pre_ff <= pre_wrap ? '0 : pre_ff + 1'b1;
      if (pre_wrap) begin
        sub_ff <= sub_wrap ? '0 : sub_ff + 1'b1;
      end
      if (sub_wrap) begin
        tmr_ff <= tmr_ff + 1'b1;
      end
    end
  end
endmodule : kwd_chain
`default_nettype wire

/* File: kwd_watchdog_sva.sv */
/* kwd_watchdog_sva: port assertions for the keyed watchdog.
   Assumes binding to kwd_watchdog and cpu_reset never looped to arst_n. */
`timescale 1ns/1ps
`default_nettype none
module kwd_watchdog_sva (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic cpu_idle,
  input wire logic power_down,
  input wire logic [kwd_pkg::KWD_PRE_W-1:0] timer_prescale,
  input wire logic reset_active_level,
  input wire logic cpu_reset,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe
);
  import kwd_pkg::*;
  // ****************************************************************
  // helper state
  // ****************************************************************
  logic key_seen_ff;
  logic strap_q_ff;
  logic [3:0] strap_age_ff;
  wire logic key_wr = reg_wr && (reg_addr == KWD_KEY_ADDR);
  // strap age lets the pin check skip the synchroniser's settling time
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_seen_ff <= 1'b0;
      strap_q_ff <= 1'b0;
      strap_age_ff <= 4'h0;
    end else begin
      key_seen_ff <= key_seen_ff | key_wr;
      strap_q_ff <= reset_active_level;
      strap_age_ff <= (strap_q_ff != reset_active_level) ? 4'h0 :
                      strap_age_ff + {3'h0, (strap_age_ff != 4'hF)};
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // ****************************************************************
  // assertions
  // ****************************************************************
  AST_RDATA_IDLE: assert property (
    !reg_rd |=> reg_rdata == 8'h00) else $error("read data not zero outside a read");
  AST_KEY_READ: assert property (
    reg_rd && reg_addr == KWD_KEY_ADDR |=> reg_rdata == 8'h00) else $error("key read gave data");
  AST_PULSE_LEN: assert property (
    $rose(cpu_reset) |=> cpu_reset ##1 !cpu_reset) else $error("reset pulse not two cycles");
  AST_OE_IN_PULSE: assert property (
    rst_pin_oe |-> cpu_reset) else $error("pin driven outside reset pulse");
  AST_SOFT_PAIR: assert property (
    (key_wr && reg_wdata == KWD_SOFT_KEY1) ##1 (key_wr && reg_wdata == KWD_SOFT_KEY2)
    |-> ##[1:3] cpu_reset) else $error("soft pair gave no reset");
  AST_BAD_KEY: assert property (
    key_wr && !(reg_wdata inside {8'h1E, 8'hE1, 8'h5A, 8'hA5}) |-> ##[1:3] cpu_reset)
    else $error("bad key gave no reset");
  AST_STOPPED: assert property (
    !key_seen_ff |-> !cpu_reset) else $error("reset pulse with no key written");
  AST_NOT_RUNNING: assert property (
    reg_rd && reg_addr == KWD_CTRL_ADDR && !key_seen_ff |=> !reg_rdata[0])
    else $error("running flag set with no key written");
  AST_PIN_LEVEL: assert property (
    strap_age_ff >= 4'h8 |-> rst_pin_out == reset_active_level) else $error("pin level wrong");
  // main scenarios reached
  COV_PULSE: cover property ($rose(cpu_reset));
  COV_PIN: cover property (rst_pin_oe);
  COV_RUN: cover property (reg_rd && reg_addr == KWD_CTRL_ADDR ##1 reg_rdata[0]);
endmodule : kwd_watchdog_sva
bind kwd_watchdog kwd_watchdog_sva kwd_watchdog_sva_i (.clk(clk), .arst_n(arst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .cpu_idle(cpu_idle), .power_down(power_down),
  .timer_prescale(timer_prescale), .reset_active_level(reset_active_level),
  .cpu_reset(cpu_reset), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));
`default_nettype wire

/* File: test_kwd_watchdog.sv */
/* test_kwd_watchdog: self-checking bench for the keyed watchdog.
   Assumes the bound checker; cpu_reset is observed, never fed back. */
`timescale 1ns/1ps
`default_nettype none
module test_kwd_watchdog;
  import kwd_pkg::*;
  logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic cpu_idle = 1'b0, power_down = 1'b0, reset_active_level = 1'b1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
  logic [6:0] timer_prescale = 7'h01;
  logic cpu_reset, rst_pin_out, rst_pin_oe, hit, oe;
  int err_count = 0, total_checks = 0, cyc = 0, rst_cnt = 0, n, t0;
  kwd_watchdog kwd_watchdog_i (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .cpu_idle(cpu_idle), .power_down(power_down), .timer_prescale(timer_prescale),
    .reset_active_level(reset_active_level), .cpu_reset(cpu_reset),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe));
  always #5 clk = ~clk;
  // cycle count and hang limit; all tests together need about 71k cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      err_count++;
      complete_run();
    end
  end
  always @(posedge cpu_reset) rst_cnt++;
  // ****************************************************************
  // bus and check tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  // two key bytes on back-to-back cycles
  task automatic key2(input logic [7:0] v1, input logic [7:0] v2);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= KWD_KEY_ADDR; reg_wdata <= v1;
    @(posedge clk);
    reg_wdata <= v2;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : key2
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic reset_dut();
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
  endtask : reset_dut
  // watch six cycles for the pulse and the pin enable
  task automatic see_pulse();
    hit = 1'b0; oe = 1'b0;
    repeat (6) begin
      @(posedge clk);
      #1 hit = hit | cpu_reset; oe = oe | rst_pin_oe;
    end
  endtask : see_pulse
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_regs();
    rd(KWD_CTRL_ADDR); chk(d, 8'h00);
    rd(KWD_KEY_ADDR); chk(d, 8'h00);
    rd(8'h55); chk(d, 8'h00);
    key2(KWD_FEED_KEY1, KWD_FEED_KEY2);
    rd(KWD_CTRL_ADDR); chk(d, 8'h01);
    wr(KWD_CTRL_ADDR, 8'h00);
    rd(KWD_CTRL_ADDR); chk(d, 8'h01);
    $display("register test done");
  endtask : t_regs
  task automatic t_timeout();
    repeat (20000) @(posedge clk);
    n = rst_cnt;
    wr(KWD_KEY_ADDR, KWD_FEED_KEY1);
    rd(KWD_CTRL_ADDR);
    wr(KWD_KEY_ADDR, KWD_FEED_KEY2);
    t0 = cyc;
    while (cpu_reset !== 1'b1 && cyc - t0 < 40000) begin
      @(posedge clk);
      #1;
    end
    chk(8'(rst_cnt - n), 8'h01);
    chk({7'h0, (cyc - t0 >= 32768) && (cyc - t0 <= 32774)}, 8'h01);
    chk({6'h0, rst_pin_oe, rst_pin_out}, 8'h03);
    rd(KWD_CTRL_ADDR); chk(d & 8'h06, 8'h02);
    $display("time-out test done");
  endtask : t_timeout
  task automatic t_soft();
    reset_dut();
    wr(KWD_CTRL_ADDR, 8'h08);
    key2(KWD_SOFT_KEY1, KWD_SOFT_KEY2);
    see_pulse(); chk({6'h0, hit, oe}, 8'h02);
    rd(KWD_CTRL_ADDR); chk(d & 8'h0E, 8'h0C);
    $display("soft reset test done");
  endtask : t_soft
  task automatic t_bad();
    reset_dut();
    wr(KWD_KEY_ADDR, KWD_FEED_KEY1);
    wr(KWD_CTRL_ADDR, 8'h00);
    see_pulse(); chk({7'h0, hit}, 8'h01);
    rd(KWD_CTRL_ADDR); chk(d & 8'h06, 8'h06);
    reset_dut();
    wr(KWD_KEY_ADDR, 8'h33);
    see_pulse(); chk({6'h0, hit, oe}, 8'h03);
    rd(KWD_CTRL_ADDR); chk(d & 8'h06, 8'h06);
    $display("bad sequence test done");
  endtask : t_bad
  // power-down freezes the count; idle freezes it only while the stop bit is set
  task automatic t_freeze();
    reset_dut();
    timer_prescale <= 7'h00;
    wr(KWD_CTRL_ADDR, 8'h10);
    key2(KWD_FEED_KEY1, KWD_FEED_KEY2);
    t0 = cyc;
    power_down <= 1'b1;
    repeat (1000) @(posedge clk);
    power_down <= 1'b0;
    cpu_idle <= 1'b1;
    repeat (1000) @(posedge clk);
    wr(KWD_CTRL_ADDR, 8'h00);
    while (cpu_reset !== 1'b1 && cyc - t0 < 25000) begin
      @(posedge clk);
      #1;
    end
    chk({7'h0, (cyc - t0 >= 18380) && (cyc - t0 <= 18395)}, 8'h01);
    cpu_idle <= 1'b0;
    $display("freeze test done");
  endtask : t_freeze
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // main sequence
  initial begin
    reset_dut();
    t_regs();
    t_timeout();
    t_soft();
    t_bad();
    t_freeze();
    complete_run();
  end
endmodule : test_kwd_watchdog
`default_nettype wire
